// ==== rtl/rx_loop_code_pkg.sv ====
package rx_loop_code_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_ACT_PATTERN = 12'h126;
  localparam logic [11:0] ADDR_DEACT_PATTERN = 12'h127;
  localparam logic [11:0] ADDR_LEN_CONTROL = 12'h12A;
  localparam logic [11:0] ADDR_DEFECT_ENABLE = 12'h12B;
  localparam logic [11:0] ADDR_LOOP_CONTROL = 12'h12C;
  localparam logic [11:0] ADDR_LOOP_STATUS = 12'h12D;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int PAT_MSB = 7;
  localparam int PAT_LSB = 1;
  localparam int PAT_EN_BIT = 0;
  localparam int ACT_LEN_MSB = 7;
  localparam int ACT_LEN_LSB = 6;
  localparam int DEACT_LEN_MSB = 5;
  localparam int DEACT_LEN_LSB = 4;
  localparam int DEFECT_BIT = 7;
  localparam int AUTO_BIT = 0;
  localparam int ST_LOOP_BIT = 0;
  localparam int ST_ACT_BIT = 1;
  localparam int ST_DEACT_BIT = 2;
  localparam logic [6:0] PATTERN_RESET = 7'h55;
  localparam logic [1:0] LEN_RESET = 2'h0;
  localparam logic DEFECT_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Detection timing
  // ----------------------------------------------------------------
  localparam int MATCH_WIDTH = 8;
  localparam logic [7:0] MATCH_BITS = 8'hA0;
  localparam logic [2:0] LEN_BASE = 3'h4;

endpackage : rx_loop_code_pkg

// ==== rtl/loop_code_matcher.sv ====
`timescale 1ns/1ps
`default_nettype none
module loop_code_matcher (
  input wire logic clock,
  input wire logic rst,
  input wire logic bit_valid,
  input wire logic [6:0] history,
  input wire logic [6:0] pattern,
  input wire logic [1:0] len_sel,
  input wire logic enable,
  output logic detected
);

  typedef struct packed {
    logic [rx_loop_code_pkg::MATCH_WIDTH-1:0] run;
    logic detected;
  } state_t;

  state_t state;
  state_t next_state;
  logic [2:0] len;
  logic [6:0] code;
  logic [6:0] mask;
  logic [6:0] rot_hit;
  logic periodic;

  // ----------------------------------------------------------------
  // Periodic compare
  // ----------------------------------------------------------------
  always_comb begin
    len = rx_loop_code_pkg::LEN_BASE + {1'b0, len_sel};
    code = pattern >> (3'h7 - len);
    mask = 7'h7F >> (3'h7 - len);
  end

  // Earliest bit is MSB
  // Line phase is unknown, so every rotation of the code is tried
  for (genvar r = 0; r < 7; r++) begin : g_phase
    logic [6:0] rotated;
    always_comb begin
      for (int i = 0; i < 7; i++) begin
        rotated[i] = code[(i + r) % len];
      end
    end
    assign rot_hit[r] = (3'(r) < len) && (((history ^ rotated) & mask) == 7'h00);
  end

  assign periodic = |rot_hit;

  always_comb begin
    next_state = state;
    if (!enable) begin
      next_state.run = '0;
      next_state.detected = 1'b0;
    end else if (bit_valid) begin
      if (!periodic) begin
        next_state.run = '0;
        next_state.detected = 1'b0;
      end else if (state.run != rx_loop_code_pkg::MATCH_BITS) begin
        next_state.run = state.run + 8'h01;
      end else begin
        next_state.detected = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign detected = state.detected;

endmodule : loop_code_matcher
`default_nettype wire

// ==== rtl/rx_loopback_code_detect.sv ====
`timescale 1ns/1ps
`default_nettype none
module rx_loopback_code_detect (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  output logic [7:0] RDATA,
  input wire logic RX_BIT,
  input wire logic RX_BIT_VALID,
  output logic REMOTE_LOOP,
  output logic DEFECT_DETECT_ON
);

  typedef struct packed {
    logic [6:0] rx_act_pattern;
    logic rx_act_detect_en;
    logic [6:0] rx_deact_pattern;
    logic rx_deact_detect_en;
    logic [1:0] rx_act_pattern_len;
    logic [1:0] rx_deact_pattern_len;
    logic defect_detect_on;
    logic auto_remote_loop_en;
    logic [6:0] history;
    logic remote_loop;
    logic [7:0] rdata;
  } state_t;

  state_t state;
  state_t next_state;
  logic act_seen;
  logic deact_seen;
  logic [7:0] read_value;

  // ----------------------------------------------------------------
  // Code matchers
  // ----------------------------------------------------------------
  // Activation search
  loop_code_matcher act_matcher (
    .clock(CLOCK),
    .rst(RST),
    .bit_valid(RX_BIT_VALID),
    .history(state.history),
    .pattern(state.rx_act_pattern),
    .len_sel(state.rx_act_pattern_len),
    .enable(state.rx_act_detect_en),
    .detected(act_seen)
  );

  loop_code_matcher deact_matcher (
    .clock(CLOCK),
    .rst(RST),
    .bit_valid(RX_BIT_VALID),
    .history(state.history),
    .pattern(state.rx_deact_pattern),
    .len_sel(state.rx_deact_pattern_len),
    .enable(state.rx_deact_detect_en),
    .detected(deact_seen)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    read_value = 8'h00;
    unique case (ADDR)
      rx_loop_code_pkg::ADDR_ACT_PATTERN: begin
        read_value = {state.rx_act_pattern, state.rx_act_detect_en};
      end
      rx_loop_code_pkg::ADDR_DEACT_PATTERN: begin
        read_value = {state.rx_deact_pattern, state.rx_deact_detect_en};
      end
      rx_loop_code_pkg::ADDR_LEN_CONTROL: begin
        read_value[rx_loop_code_pkg::ACT_LEN_MSB:rx_loop_code_pkg::ACT_LEN_LSB] =
          state.rx_act_pattern_len;
        read_value[rx_loop_code_pkg::DEACT_LEN_MSB:rx_loop_code_pkg::DEACT_LEN_LSB] =
          state.rx_deact_pattern_len;
      end
      rx_loop_code_pkg::ADDR_DEFECT_ENABLE: begin
        read_value[rx_loop_code_pkg::DEFECT_BIT] = state.defect_detect_on;
      end
      rx_loop_code_pkg::ADDR_LOOP_CONTROL: begin
        read_value[rx_loop_code_pkg::AUTO_BIT] = state.auto_remote_loop_en;
      end
      rx_loop_code_pkg::ADDR_LOOP_STATUS: begin
        read_value[rx_loop_code_pkg::ST_LOOP_BIT] = state.remote_loop;
        read_value[rx_loop_code_pkg::ST_ACT_BIT] = act_seen;
        read_value[rx_loop_code_pkg::ST_DEACT_BIT] = deact_seen;
      end
      default: begin
        read_value = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.rdata = READ ? read_value : 8'h00;
    if (WRITE) begin
      unique case (ADDR)
        rx_loop_code_pkg::ADDR_ACT_PATTERN: begin
          next_state.rx_act_pattern =
            WDATA[rx_loop_code_pkg::PAT_MSB:rx_loop_code_pkg::PAT_LSB];
          next_state.rx_act_detect_en = WDATA[rx_loop_code_pkg::PAT_EN_BIT];
        end
        rx_loop_code_pkg::ADDR_DEACT_PATTERN: begin
          next_state.rx_deact_pattern =
            WDATA[rx_loop_code_pkg::PAT_MSB:rx_loop_code_pkg::PAT_LSB];
          next_state.rx_deact_detect_en = WDATA[rx_loop_code_pkg::PAT_EN_BIT];
        end
        rx_loop_code_pkg::ADDR_LEN_CONTROL: begin
          next_state.rx_act_pattern_len =
            WDATA[rx_loop_code_pkg::ACT_LEN_MSB:rx_loop_code_pkg::ACT_LEN_LSB];
          next_state.rx_deact_pattern_len =
            WDATA[rx_loop_code_pkg::DEACT_LEN_MSB:rx_loop_code_pkg::DEACT_LEN_LSB];
        end
        rx_loop_code_pkg::ADDR_DEFECT_ENABLE: begin
          next_state.defect_detect_on = WDATA[rx_loop_code_pkg::DEFECT_BIT];
        end
        rx_loop_code_pkg::ADDR_LOOP_CONTROL: begin
          next_state.auto_remote_loop_en = WDATA[rx_loop_code_pkg::AUTO_BIT];
        end
        default: begin
        end
      endcase
    end
    if (RX_BIT_VALID) begin
      next_state.history = {state.history[5:0], RX_BIT};
    end
    if (!state.auto_remote_loop_en) begin
      next_state.remote_loop = 1'b0;
    end else if (deact_seen) begin
      next_state.remote_loop = 1'b0;
    end else if (act_seen) begin
      next_state.remote_loop = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state <= '0;
      state.rx_act_pattern <= rx_loop_code_pkg::PATTERN_RESET;
      state.rx_deact_pattern <= rx_loop_code_pkg::PATTERN_RESET;
      state.rx_act_pattern_len <= rx_loop_code_pkg::LEN_RESET;
      state.rx_deact_pattern_len <= rx_loop_code_pkg::LEN_RESET;
      state.defect_detect_on <= rx_loop_code_pkg::DEFECT_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign RDATA = state.rdata;
  assign REMOTE_LOOP = state.remote_loop;
  assign DEFECT_DETECT_ON = state.defect_detect_on;

endmodule : rx_loopback_code_detect
`default_nettype wire

// ==== verif/rx_loop_code_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module rx_loop_code_checker (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  input wire logic [7:0] RDATA,
  input wire logic RX_BIT,
  input wire logic RX_BIT_VALID,
  input wire logic REMOTE_LOOP,
  input wire logic DEFECT_DETECT_ON
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_rdata_idle: assert property (
    !READ |=> RDATA == 8'h00) else $error("read data not zero outside read");
  a_unmapped_read: assert property (
    READ && (ADDR < 12'h126 || ADDR > 12'h12D) |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_deact_readback: assert property (
    WRITE && ADDR == 12'h127 ##2 READ && ADDR == 12'h127 |=> RDATA == $past(WDATA, 3))
    else $error("pattern readback wrong");
  a_defect_mirror: assert property (
    WRITE && ADDR == 12'h12B |=> DEFECT_DETECT_ON == $past(WDATA[7]))
    else $error("defect output not written value");
  a_defect_hold: assert property (
    !(WRITE && ADDR == 12'h12B) |=> $stable(DEFECT_DETECT_ON))
    else $error("defect output moved without write");
  a_reset_quiet: assert property (
    $fell(RST) |-> !REMOTE_LOOP && RDATA == 8'h00 && !DEFECT_DETECT_ON)
    else $error("outputs not cleared by reset");
  a_loop_hold: assert property (
    (!RX_BIT_VALID && !WRITE) [*4] |=> $stable(REMOTE_LOOP))
    else $error("loop changed with no line bits");
  a_loop_rise_cause: assert property (
    $rose(REMOTE_LOOP) |-> $past(RX_BIT_VALID, 2) || $past(WRITE) || $past(WRITE, 2) ||
      $past(WRITE, 3))
    else $error("loop rose without cause");
  a_auto_off: assert property (
    WRITE && ADDR == 12'h12C && !WDATA[0] |-> ##[1:3] !REMOTE_LOOP)
    else $error("loop kept with auto off");
  c_loop_on: cover property ($rose(REMOTE_LOOP));
  c_loop_off: cover property ($fell(REMOTE_LOOP));
  c_deact_read: cover property (READ && ADDR == 12'h127);
endmodule : rx_loop_code_checker

bind rx_loopback_code_detect rx_loop_code_checker chk_u (.CLOCK(CLOCK), .RST(RST),
  .ADDR(ADDR), .WDATA(WDATA), .WRITE(WRITE), .READ(READ), .RDATA(RDATA),
  .RX_BIT(RX_BIT), .RX_BIT_VALID(RX_BIT_VALID), .REMOTE_LOOP(REMOTE_LOOP),
  .DEFECT_DETECT_ON(DEFECT_DETECT_ON));
`default_nettype wire

// ==== verif/far_end_sender.sv ====
`timescale 1ns/1ps
`default_nettype none
module far_end_sender (
  input wire logic clock,
  input wire logic rst,
  input wire logic run,
  input wire logic [6:0] code,
  input wire logic [2:0] len,
  output logic line_bit,
  output logic line_valid
);
  logic [2:0] pos;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pos <= 3'h0;
      line_bit <= 1'b0;
      line_valid <= 1'b0;
    end else if (run && !line_valid) begin
      // top bits of code, MSB first
      line_bit <= code[3'h6 - pos];
      line_valid <= 1'b1;
      pos <= (pos == len - 3'h1) ? 3'h0 : pos + 3'h1;
    end else begin
      // Idle line never holds a stale bit
      line_bit <= ~line_bit;
      line_valid <= 1'b0;
      if (!run) pos <= 3'h0;
    end
  end
endmodule : far_end_sender
`default_nettype wire

// ==== verif/rx_loopback_code_detect_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module rx_loopback_code_detect_test;
  logic CLOCK = 1'b0, RST = 1'b1, WRITE = 1'b0, READ = 1'b0, RX_BIT, RX_BIT_VALID;
  logic REMOTE_LOOP, DEFECT_DETECT_ON, run = 1'b0;
  logic [11:0] ADDR = 12'h000;
  logic [7:0] WDATA = 8'h00, RDATA;
  logic [6:0] code = 7'h00;
  logic [2:0] len = 3'h4;
  int error_cnt = 0, checks_done = 0;
  always #5 CLOCK = ~CLOCK;
  rx_loopback_code_detect dut_u (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WRITE(WRITE), .READ(READ), .RDATA(RDATA), .RX_BIT(RX_BIT), .RX_BIT_VALID(RX_BIT_VALID),
    .REMOTE_LOOP(REMOTE_LOOP), .DEFECT_DETECT_ON(DEFECT_DETECT_ON));
  far_end_sender far_u (.clock(CLOCK), .rst(RST), .run(run), .code(code), .len(len),
    .line_bit(RX_BIT), .line_valid(RX_BIT_VALID));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= d;
    WRITE <= 1'b1;
    @(posedge CLOCK);
    WRITE <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
    @(posedge CLOCK);
    ADDR <= a;
    READ <= 1'b1;
    @(posedge CLOCK);
    READ <= 1'b0;
    @(negedge CLOCK);
    chk(n, e, RDATA);
  endtask : rd
  task automatic send(input logic [6:0] c, input logic [2:0] l);
    @(posedge CLOCK);
    code <= c;
    len <= l;
    run <= 1'b1;
    repeat (420) @(posedge CLOCK);
    run <= 1'b0;
    repeat (4) @(posedge CLOCK);
    @(negedge CLOCK);
  endtask : send
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial begin
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    rd(12'h127, 8'hAA, "deact_reset");
    rd(12'h126, 8'hAA, "act_reset");
    rd(12'h12A, 8'h00, "len_reset");
    rd(12'h12B, 8'h00, "defect_reset");
    rd(12'h000, 8'h00, "unmapped");
    wr(12'h12A, 8'hFF);
    rd(12'h12A, 8'hF0, "len_rw");
    wr(12'h12B, 8'hFF);
    rd(12'h12B, 8'h80, "defect_rw");
    chk("defect_pin", 8'h01, {7'h00, DEFECT_DETECT_ON});
    $display("register test done");
    wr(12'h12A, 8'hC0);
    wr(12'h12C, 8'h01);
    rd(12'h12C, 8'h01, "auto_rw");
    wr(12'h126, 8'hCA);
    wr(12'h126, 8'hCB);
    send(7'h65, 3'h7);
    chk("loop_on", 8'h01, {7'h00, REMOTE_LOOP});
    rd(12'h12D, 8'h03, "status_on");
    wr(12'h127, 8'h96);
    rd(12'h127, 8'h96, "deact_rw");
    send(7'h4B, 3'h4);
    chk("deact_off", 8'h01, {7'h00, REMOTE_LOOP});
    rd(12'h12D, 8'h01, "status_held");
    wr(12'h127, 8'h97);
    send(7'h4B, 3'h4);
    chk("loop_off", 8'h00, {7'h00, REMOTE_LOOP});
    rd(12'h12D, 8'h04, "status_off");
    wr(12'h12C, 8'h00);
    wr(12'h12A, 8'h60);
    send(7'h65, 3'h5);
    chk("auto_off", 8'h00, {7'h00, REMOTE_LOOP});
    rd(12'h12D, 8'h02, "act_len5");
    send(7'h4B, 3'h6);
    rd(12'h12D, 8'h04, "deact_len6");
    $display("detect test done");
    conclude();
  end
  initial begin
    repeat (5000) @(posedge CLOCK);
    error_cnt++;
    conclude();
  end
endmodule : rx_loopback_code_detect_test
`default_nettype wire
